// >>> src/sdc_core.v
// Divider configuration, serial/parallel load and test pin select
// Overview of operation
// - Crystal reference divided by eight before detector
// - Test field selects test pin source
// - Bypass feeds serial clock into both dividers
// - Bypass: output divider drives differential output
// - Test field takes nonzero codes only from serial stream
// - Parallel strobe low forces test field zero
// - Serial order: test, output, loop fields
// - Each field shifted most significant bit first
// - Loop counter test waveform not symmetric
// - Output code selects divide 2/4/8/16
// - Shift register advances on serial clock rise
// - Serial latches transparent while load high
// - Parallel load wins, captured on strobe rise
`default_nettype none
`include "sdc_defines.vh"

module sdc_core (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       crystal_clk_en,
  input  wire       osc_clk_en,
  input  wire       ser_clk,
  input  wire       ser_data,
  input  wire       ser_load,
  input  wire       par_load_n,
  input  wire [8:0] par_m,
  input  wire [1:0] par_n,
  output reg        synth_clock_out,
  output reg        synth_clock_out_n,
  output reg        test_out,
  output reg        divided_reference,
  output reg        fb_to_detector,
  output reg  [8:0] loop_div_r,
  output reg  [1:0] out_div_r,
  output reg  [2:0] test_sel_r,
  output reg        bypass_r
);

  reg  [13:0] shift_r;
  reg         ser_clk_d_r;
  reg  [2:0]  ref_cnt_r;
  reg  [8:0]  m_cnt_r;
  reg         m_pulse_r;
  reg         synth_clock_out_n_d_r;
  wire        ser_rise;
  wire        bypass_sel;
  wire        step_src;
  wire        n_wrap;
  wire        n_out;
  wire        q_out;
  wire        q_step;
  reg  [8:0]  n_half;
  reg         test_nxt;

  // ****************************************
  // Edge detection of pins sampled on core_clk
  // ****************************************
  // Reset low matches the idle serial clock, so no false rise follows reset
  assign ser_rise = ser_clk & ~ser_clk_d_r;

  always @(posedge core_clk) begin
    if (rst) begin
      ser_clk_d_r <= 1'b0;
    end else begin
      ser_clk_d_r <= ser_clk;
    end
  end

  // ****************************************
  // Serial shift register
  // ****************************************
  // One bit per serial clock rise; first bit ends up at the top
  always @(posedge core_clk) begin
    if (rst) begin
      shift_r <= 14'h0000;
    end else if (ser_rise) begin
      shift_r <= {shift_r[`SDC_SR_W-2:0], ser_data};
    end
  end

  // ****************************************
  // Configuration latches
  // ****************************************
  // Latch modelled as a flop: follows while enabled, holds otherwise.
  // Parallel strobe low overrides any serial activity.
  always @(posedge core_clk) begin
    if (rst) begin
      loop_div_r <= `SDC_M_RST;
      out_div_r  <= `SDC_N_RST;
      test_sel_r <= `SDC_T_RST;
    end else if (!par_load_n) begin
      loop_div_r <= par_m;
      out_div_r  <= par_n;
      test_sel_r <= `SDC_T_SRLAST;
    end else if (ser_load) begin
      test_sel_r <= shift_r[`SDC_SR_T_HI:`SDC_SR_T_LO];
      out_div_r  <= shift_r[`SDC_SR_N_HI:`SDC_SR_N_LO];
      loop_div_r <= shift_r[`SDC_SR_M_HI:`SDC_SR_M_LO];
    end
  end

  // ****************************************
  // Bypass decode
  // ****************************************
  assign bypass_sel = (test_sel_r == `SDC_T_BYPASS);
  assign step_src   = bypass_sel ? ser_rise : osc_clk_en;

  always @(posedge core_clk) begin
    if (rst) begin
      bypass_r <= 1'b0;
    end else begin
      bypass_r <= bypass_sel;
    end
  end

  // ****************************************
  // Reference pre-divider by eight
  // ****************************************
  // Toggle every four crystal steps gives one output period per eight
  always @(posedge core_clk) begin
    if (rst) begin
      ref_cnt_r         <= 3'h0;
      divided_reference <= 1'b0;
    end else if (crystal_clk_en) begin
      if (ref_cnt_r >= `SDC_REF_HALF) begin
        ref_cnt_r         <= 3'h0;
        divided_reference <= ~divided_reference;
      end else begin
        ref_cnt_r <= ref_cnt_r + 3'h1;
      end
    end
  end

  // ****************************************
  // Loop counter
  // ****************************************
  // Single-step pulse per wrap: cheap, but the duty is not 50%
  always @(posedge core_clk) begin
    if (rst) begin
      m_cnt_r   <= 9'h000;
      m_pulse_r <= 1'b0;
    end else if (step_src) begin
      if (m_cnt_r + 9'h001 >= loop_div_r) begin
        m_cnt_r   <= 9'h000;
        m_pulse_r <= 1'b1;
      end else begin
        m_cnt_r   <= m_cnt_r + 9'h001;
        m_pulse_r <= 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      fb_to_detector <= 1'b0;
    end else begin
      fb_to_detector <= m_pulse_r;
    end
  end

  // ****************************************
  // Output divider ratio decode
  // ****************************************
  always @* begin
    case (out_div_r)
      `SDC_N_CODE2:  n_half = `SDC_NDIV2;
      `SDC_N_CODE4:  n_half = `SDC_NDIV4;
      `SDC_N_CODE8:  n_half = `SDC_NDIV8;
      `SDC_N_CODE16: n_half = `SDC_NDIV16;
      default:       n_half = `SDC_NDIV2;
    endcase
  end

  // Toggle divider keeps the output symmetric
  sdc_toggle_div u_ndiv (
    .core_clk  (core_clk),
    .rst       (rst),
    .step_en   (step_src),
    .half_cnt  (n_half),
    .div_out_r (n_out),
    .wrap_r    (n_wrap)
  );

  // Wrap fires on both halves; only the rising one marks a full output period
  assign q_step = n_wrap & n_out;

  // Output divided by four for the test pin
  sdc_toggle_div u_qdiv (
    .core_clk  (core_clk),
    .rst       (rst),
    .step_en   (q_step),
    .half_cnt  (`SDC_DIV4_HALF),
    .div_out_r (q_out),
    .wrap_r    ()
  );

  // ****************************************
  // Differential output
  // ****************************************
  // Same divider in both modes; only its step source changes
  always @(posedge core_clk) begin
    if (rst) begin
      synth_clock_out   <= 1'b0;
      synth_clock_out_n <= 1'b1;
      synth_clock_out_n_d_r          <= 1'b0;
    end else begin
      synth_clock_out   <= n_out;
      synth_clock_out_n <= ~n_out;
      synth_clock_out_n_d_r          <= n_out;
    end
  end

  // ****************************************
  // Test pin select
  // ****************************************
  always @* begin
    case (test_sel_r)
      `SDC_T_SRLAST: test_nxt = shift_r[`SDC_SR_LAST];
      `SDC_T_HIGH:   test_nxt = 1'b1;
      `SDC_T_DIVIDED_REFERENCE:   test_nxt = divided_reference;
      `SDC_T_MCNT:   test_nxt = m_pulse_r;
      `SDC_T_SYNTH_CLOCK_OUT_N:   test_nxt = synth_clock_out_n_d_r;
      `SDC_T_LOW:    test_nxt = 1'b0;
      `SDC_T_BYPASS: test_nxt = m_pulse_r;
      `SDC_T_FOUT4:  test_nxt = q_out;
      default:       test_nxt = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      test_out <= 1'b0;
    end else begin
      test_out <= test_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> src/sdc_defines.vh
// Constants for the synthesizer divider configuration and test-select block
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// ****************************************
// Field widths and serial frame layout
// ****************************************
`define SDC_M_W        9
`define SDC_N_W        2
`define SDC_T_W        3
`define SDC_SR_W       14
`define SDC_SR_T_HI    13
`define SDC_SR_T_LO    11
`define SDC_SR_N_HI    10
`define SDC_SR_N_LO    9
`define SDC_SR_M_HI    8
`define SDC_SR_M_LO    0
`define SDC_SR_LAST    13

// ****************************************
// Reference pre-divide and output ratios
// ****************************************
`define SDC_REF_HALF   3'h3
`define SDC_CNT_W      9
`define SDC_NDIV2      9'h000
`define SDC_NDIV4      9'h001
`define SDC_NDIV8      9'h003
`define SDC_NDIV16     9'h007
`define SDC_N_CODE2    2'h0
`define SDC_N_CODE4    2'h1
`define SDC_N_CODE8    2'h2
`define SDC_N_CODE16   2'h3
`define SDC_DIV4_HALF  9'h001

// ****************************************
// Test-select codes
// ****************************************
`define SDC_T_SRLAST   3'h0
`define SDC_T_HIGH     3'h1
`define SDC_T_DIVIDED_REFERENCE     3'h2
`define SDC_T_MCNT     3'h3
`define SDC_T_SYNTH_CLOCK_OUT_N     3'h4
`define SDC_T_LOW      3'h5
`define SDC_T_BYPASS   3'h6
`define SDC_T_FOUT4    3'h7

// ****************************************
// Reset values
// ****************************************
`define SDC_M_RST      9'h0c8
`define SDC_N_RST      2'h0
`define SDC_T_RST      3'h0

`endif

// >>> src/sdc_toggle_div.v
// Enable-driven toggle divider with programmable half period
`default_nettype none

module sdc_toggle_div (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       step_en,
  input  wire [8:0] half_cnt,
  output reg        div_out_r,
  output reg        wrap_r
);

  reg [8:0] cnt_r;

  // ****************************************
  // Count input steps, toggle on terminal
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_r     <= 9'h000;
      div_out_r <= 1'b0;
      wrap_r    <= 1'b0;
    end else begin
      wrap_r <= 1'b0;
      if (step_en) begin
        if (cnt_r >= half_cnt) begin
          cnt_r     <= 9'h000;
          div_out_r <= ~div_out_r;
          wrap_r    <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 9'h001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> dv/sdc_chk.sv
// Port checks for the divider configuration block
`default_nettype none
module sdc_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ser_load,
  input wire logic       par_load_n,
  input wire logic [8:0] par_m,
  input wire logic [1:0] par_n,
  input wire logic       synth_clock_out,
  input wire logic       synth_clock_out_n,
  input wire logic       test_out,
  input wire logic [8:0] loop_div_r,
  input wire logic [1:0] out_div_r,
  input wire logic [2:0] test_sel_r,
  input wire logic       bypass_r
);
  timeunit 1ns;
  timeprecision 100ps;
  // ******
  // Checks
  // ******
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Strobe states
  sequence s_par; !par_load_n; endsequence
  sequence s_quiet; par_load_n && !ser_load; endsequence
  property p_cap; s_par |=> loop_div_r == $past(par_m) && out_div_r == $past(par_n); endproperty
  a_cap: assert property (p_cap) else $error("pins not taken");
  property p_t0; s_par |=> test_sel_r == 3'h0; endproperty
  a_t0: assert property (p_t0) else $error("test not cleared");
  property p_hold; s_quiet |=> $stable({loop_div_r, out_div_r, test_sel_r}); endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  // Reset edge excluded: the field jumps to its reset value there
  property p_src; !$past(rst) && $changed(test_sel_r) |-> $past(ser_load || !par_load_n); endproperty
  a_src: assert property (p_src) else $error("test field source");
  property p_byp; 1 |=> bypass_r == ($past(test_sel_r) == 3'h6); endproperty
  a_byp: assert property (p_byp) else $error("bypass flag");
  property p_hi; test_sel_r == 3'h1 |=> test_out; endproperty
  a_hi: assert property (p_hi) else $error("test not high");
  property p_lo; test_sel_r == 3'h5 |=> !test_out; endproperty
  a_lo: assert property (p_lo) else $error("test not low");
  property p_pair; synth_clock_out_n != synth_clock_out; endproperty
  a_pair: assert property (p_pair) else $error("pair equal");
endmodule
bind sdc_core sdc_chk i_chk (.*);
`default_nettype wire

// >>> dv/sdc_ctl_model.sv
// Board controller model driving the serial configuration port
`default_nettype none
module sdc_ctl_model (
  input  wire logic core_clk,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_load
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Port
  // ****
  logic busy = 0;
  initial begin
    ser_clk = 0;
    ser_data = 0;
    ser_load = 0;
  end
  // Data toggles between frames so a stale bit cannot pass for a held one
  always @(posedge core_clk)
    if (!busy) ser_data <= #1 ~ser_data;
  // Test, output, loop fields, msb first; h cycles low and h + 1 cycles high per serial clock
  task automatic send(input logic [13:0] f, input int h, input logic ld);
    busy = 1;
    for (int i = 13; i >= 0; i--) begin
      @(posedge core_clk);
      #1 ser_clk = 0;
      ser_data = f[i];
      repeat (h) @(posedge core_clk);
      #1 ser_clk = 1;
      repeat (h) @(posedge core_clk);
    end
    @(posedge core_clk);
    #1 ser_clk = 0;
    ser_load = ld;
    repeat (h + 1) @(posedge core_clk);
    #1 ser_load = 0;
    busy = 0;
  endtask
endmodule
`default_nettype wire

// >>> dv/sdc_core_tb.sv
// Self-checking bench for the divider configuration block
`default_nettype none
module sdc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Bench
  // *****
  logic        core_clk = 0, rst = 1, crystal_clk_en = 0, osc_clk_en = 0, par_load_n = 1, rnd = 1, pso = 0;
  logic        ser_clk, ser_data, ser_load, synth_clock_out, synth_clock_out_n, test_out;
  logic        divided_reference, fb_to_detector, bypass_r;
  logic [8:0]  par_m = 9'h0c8, loop_div_r, m;
  logic [1:0]  par_n = 2'h0, out_div_r;
  logic [2:0]  test_sel_r;
  logic [13:0] f;
  logic [15:0] lfsr = 16'h0043;
  logic [2:0]  tcode [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
  int          miscompares = 0, cmp_count = 0, cyc = 0, tg = 0, p;
  sdc_core i_dut (.*);
  sdc_ctl_model i_ctl (.*);
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] ratio(input logic [1:0] n);
    return 16'h0002 << n;
  endfunction
  // Expected test pin period for each routed node, in steady-enable cycles
  function automatic int test_period(input logic [2:0] t, input logic [8:0] lm, input logic [1:0] n);
    case (t)
      3'h2:    return 8;
      3'h3:    return int'(lm);
      3'h4:    return int'(ratio(n));
      default: return 4 * int'(ratio(n));
    endcase
  endfunction
  function automatic logic pick(input int k);
    return k == 0 ? synth_clock_out : k == 1 ? divided_reference : k == 2 ? fb_to_detector : test_out;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Second full period, so a reload's first ragged cycle is skipped
  task automatic per(input int k, output int n);
    int r;
    int w;
    logic q;
    r = 0;
    w = 0;
    n = 0;
    q = 1;
    while (r < 3 && w < 2000) begin
      @(posedge core_clk);
      #2 w++;
      if (pick(k) && !q) r++;
      if (r == 2) n++;
      q = pick(k);
    end
  endtask
  // Pins scrambled after the strobe to show the latches hold
  task automatic pload(input logic [8:0] pm, input logic [1:0] pn);
    @(posedge core_clk);
    #1 par_load_n = 0;
    par_m = pm;
    par_n = pn;
    @(posedge core_clk);
    #1 par_load_n = 1;
    par_m = ~pm;
    par_n = ~pn;
    @(posedge core_clk);
    #1 chk({loop_div_r, out_div_r}, {pm, pn});
    chk(test_sel_r, 3'h0);
  endtask
  initial forever #4 core_clk = ~core_clk;
  // Random enables, output toggle count, watchdog
  always @(posedge core_clk) begin
    lfsr <= nxt(lfsr);
    {crystal_clk_en, osc_clk_en} <= #1 rnd ? lfsr[1:0] : 2'h3;
    pso <= synth_clock_out;
    tg <= tg + (synth_clock_out != pso);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 0;
    pload(9'(9'h0c8 + lfsr % 16'h00c9), lfsr[1:0]);
    // Every test code through the serial port, fast and slow
    for (int t = 0; t < 8; t++) begin
      m = 9'(9'h0c8 + lfsr % 16'h00c9);
      f = {3'(t), lfsr[3:2], m};
      i_ctl.send(f, 1 + t % 3, 1'h1);
      repeat (3) @(posedge core_clk);
      #1 chk({test_sel_r, out_div_r, loop_div_r}, f);
      if (t < 2 || t == 5) chk(test_out, t == 1);
    end
    pload(m, 2'h1);
    rnd = 0;
    for (int n = 0; n < 4; n++) begin
      m = n[0] ? 9'h190 : 9'h0c8;
      pload(m, 2'(n));
      per(0, p);
      chk(16'(p), ratio(2'(n)));
      per(1, p);
      chk(16'(p), 16'h0008);
      per(2, p);
      chk(16'(p), 16'(m));
    end
    // Routed test nodes by period; loop value retuned one step per frame
    for (int k = 0; k < 4; k++) begin
      m = 9'(9'h0c8 + k);
      i_ctl.send({tcode[k], 2'(k), m}, 1, 1'h1);
      per(3, p);
      chk(16'(p), 16'(test_period(tcode[k], m, 2'(k))));
    end
    // Bypass: oscillator running, only serial clock rises may move the output
    i_ctl.send({3'h6, 2'h0, 9'h0c8}, 2, 1'h1);
    repeat (3) @(posedge core_clk);
    #1 chk(bypass_r, 1'b1);
    p = tg;
    i_ctl.send(14'h0000, 2, 1'h0);
    repeat (3) @(posedge core_clk);
    #1 chk(16'(tg - p), 16'h000e);
    // Mid-run reset: latches and outputs fall back to their reset values
    rst = 1;
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    chk({loop_div_r, out_div_r, test_sel_r, bypass_r}, {9'h0c8, 2'h0, 3'h0, 1'b0});
    chk({synth_clock_out, synth_clock_out_n, test_out, divided_reference, fb_to_detector}, 16'h0008);
    repeat (2) @(posedge core_clk);
    finish_test();
  end
endmodule
`default_nettype wire
